// ===== mca_datapath.sv
`timescale 1ns/10ps
module mca_datapath (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // Instruction from sequencer
   input  wire logic                        instrValid,
   input  wire logic [mca_pkg::W-1:0]       instrEven,
   input  wire logic [mca_pkg::W-1:0]       instrOdd,
   output logic                             instrReady,
   // Microprogram ROM table port
   output logic [mca_pkg::W-1:0]            romAddr,
   input  wire logic [mca_pkg::W-1:0]       romData,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic [31:0]                      hrdata,
   output logic                             hresp
);
   import mca_pkg::*;

   typedef enum logic {ST_IDLE, ST_LOAD} mca_state_e;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [W-1:0]    regFile_q [NREG];
   mca_state_e      state_q;
   logic            carry_q;
   logic            ovfl_q;
   logic            shc_q;
   logic            run_q;
   logic [SELW-1:0] regSel_q;
   logic [SELW-1:0] ldB_q;
   logic [SELW-1:0] ldD_q;
   logic [W-1:0]    romAddr_q;

   // Doc bit k of a word is Verilog bit W-1-k
   function automatic logic docBit(input logic [W-1:0] w, input int k);
      docBit = w[W-1-k];
   endfunction

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   logic [SELW-1:0] bSel;
   logic [SELW-1:0] dSel;
   logic [SELW-1:0] aSel;
   logic [2:0]      shfCode;

   always_comb begin
      for (int i = 0; i < SELW; i++) begin
         bSel[SELW-1-i] = docBit(instrEven, BSEL_POS[i]);
         dSel[SELW-1-i] = docBit(instrEven, DSEL_POS[i]);
         aSel[SELW-1-i] = docBit(instrOdd, ASEL_POS[i]);
      end
      for (int i = 0; i < 3; i++) begin
         shfCode[2-i] = docBit(instrOdd, SHF_POS[i]);
      end
   end

   wire logic [3:0] opcode = instrEven[W-1 -: 4];
   wire mca_shift_e shMode = mca_shift_e'(shfCode);
   wire logic modSo = docBit(instrOdd, SO_POS);
   wire logic modSi = docBit(instrOdd, SI_POS);
   wire logic modCi = docBit(instrOdd, CI_POS);
   wire logic modP1 = docBit(instrOdd, P1_POS);

   wire logic isAnd  = (opcode == OP_AND);
   wire logic isOr   = (opcode == OP_OR);
   wire logic isXor  = (opcode == OP_XOR);
   wire logic isAdd  = (opcode == OP_ADD);
   wire logic isDiv  = (opcode == OP_DIV);
   wire logic isAndi = (opcode == OP_AND_IMMEDIATE);
   wire logic isOri  = (opcode == OP_ORI);
   wire logic isXori = (opcode == OP_XOR_IMMEDIATE);
   wire logic isAddi = (opcode == OP_ADD_IMMEDIATE);
   wire logic isLoad = (opcode == OP_LOAD);
   wire logic isRr   = isAnd | isOr | isXor | isAdd | isDiv;
   wire logic isImm  = isAndi | isOri | isXori | isAddi;
   wire logic isArith = isAdd | isDiv;

   // ----------------------------------------------------------------
   // Buses and arithmetic/logic unit
   // ----------------------------------------------------------------
   wire logic [W-1:0] bBus = regFile_q[bSel];
   wire logic [W-1:0] aBus = isImm ? instrOdd : regFile_q[aSel];

   wire logic modCiEff = isArith & modCi;
   wire logic modP1Eff = isArith & modP1;
   wire logic carryIn  = (modCiEff & carry_q) | modP1Eff;

   wire logic [W:0]   sumFull = {1'b0, aBus} + {1'b0, bBus}
                                + {{W{1'b0}}, carryIn};
   wire logic [W-1:0] sumLow  = {1'b0, aBus[W-2:0]} + {1'b0, bBus[W-2:0]}
                                + {{(W-1){1'b0}}, carryIn};
   wire logic         carry0  = sumFull[W];
   wire logic         carry1  = sumLow[W-1];
   wire logic         ovflNew = carry0 ^ carry1;
   wire logic [W-1:0] sum     = sumFull[W-1:0];

   logic [W-1:0] aluOut;
   always_comb begin
      if (isAnd | isAndi) begin
         aluOut = bBus & aBus;
      end else if (isOr | isOri) begin
         aluOut = bBus | aBus;
      end else if (isXor | isXori) begin
         aluOut = bBus ^ aBus;
      end else begin
         aluOut = sum;
      end
   end

   // ----------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------
   wire logic sclCarry = isArith ? carry0 : carry_q;
   wire logic fill1    = modSi & shc_q;
   wire logic fillSk   = sclCarry | (modSi & shc_q);
   wire logic spillMsb = (shMode == SH_NONE) | (shMode == SH_L1)
                         | (shMode == SH_SE) | (shMode == SH_L8);
   wire logic spillBit = spillMsb ? aluOut[W-1] : aluOut[0];

   logic [W-1:0] shOut;
   always_comb begin
      case (shMode)
         SH_NONE: begin
            shOut = aluOut;
         end
         SH_R1: begin
            shOut = {fill1, aluOut[W-1:1]};
         end
         SH_L1: begin
            shOut = {aluOut[W-2:0], fill1};
         end
         SH_SK: begin
            shOut = {fillSk, aluOut[W-1:1]};
         end
         SH_SE: begin
            shOut = {{(W/2){aluOut[W/2-1]}}, aluOut[W/2-1:0]};
         end
         SH_R8: begin
            shOut = aluOut >> (W/2);
         end
         SH_L8: begin
            shOut = aluOut << (W/2);
         end
         SH_EX: begin
            shOut = {aluOut[W/2-1:0], aluOut[W-1:W/2]};
         end
         default: begin
            shOut = aluOut;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencing and write-back
   // ----------------------------------------------------------------
   wire logic idle     = (state_q == ST_IDLE);
   assign instrReady   = run_q & idle;
   wire logic take     = instrValid & instrReady;
   wire logic divKeep  = isDiv & sum[W-1];
   wire logic loadDone = (state_q == ST_LOAD);

   logic            wrEn;
   logic [SELW-1:0] wrIdx;
   logic [W-1:0]    wrData;
   always_comb begin
      wrEn   = 1'b0;
      wrIdx  = dSel;
      wrData = shOut;
      if (loadDone) begin
         wrEn   = 1'b1;
         wrIdx  = ldD_q;
         wrData = romData ^ regFile_q[ldB_q];
      end else if (take & isImm) begin
         wrEn   = 1'b1;
         wrData = aluOut;
      end else if (take & isRr) begin
         wrEn   = ~divKeep;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else if (take & isLoad) begin
         state_q <= ST_LOAD;
      end else if (loadDone) begin
         state_q <= ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ldB_q     <= '0;
         ldD_q     <= '0;
         romAddr_q <= '0;
      end else if (take & isLoad) begin
         ldB_q     <= bSel;
         ldD_q     <= dSel;
         romAddr_q <= regFile_q[LINK_REG] | instrOdd;
      end
   end
   assign romAddr = romAddr_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         carry_q <= 1'b0;
         ovfl_q  <= 1'b0;
      end else if (take & isArith) begin
         carry_q <= carry0;
         ovfl_q  <= ovflNew;
      end
   end

   // Spill only for register-register forms
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shc_q <= 1'b0;
      end else if (take & isRr & modSo) begin
         shc_q <= spillBit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < NREG; i++) begin
            regFile_q[i] <= '0;
         end
      end else if (wrEn) begin
         regFile_q[wrIdx] <= wrData;
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite register slave
   // ----------------------------------------------------------------
   logic          busWr_q;
   logic [AW-1:0] busAddr_q;
   logic [31:0]   rdata_q;

   wire logic          addrPhase = hsel & htrans[1] & hready;
   wire logic [AW-1:0] aOff      = haddr[AW-1:0];
   wire logic [31:0]   stWord    = {28'h0000000, ~idle, shc_q, ovfl_q,
                                    carry_q};
   wire logic [31:0]   ctWord    = {31'h00000000, run_q};
   wire logic [31:0]   selWord   = {27'h0000000, regSel_q};
   wire logic [31:0]   datWord   = {16'h0000, regFile_q[regSel_q]};

   logic [31:0] rdNext;
   always_comb begin
      case (aOff)
         A_CTRL:   rdNext = ctWord;
         A_STATUS: rdNext = stWord;
         A_REGSEL: rdNext = selWord;
         A_REGDAT: rdNext = datWord;
         default:  rdNext = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busWr_q   <= 1'b0;
         busAddr_q <= '0;
         rdata_q   <= 32'h00000000;
      end else begin
         busWr_q <= addrPhase & hwrite;
         if (addrPhase) begin
            busAddr_q <= aOff;
            rdata_q   <= hwrite ? 32'h00000000 : rdNext;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         run_q    <= CTRL_RUN_RST;
         regSel_q <= '0;
      end else if (busWr_q) begin
         if (busAddr_q == A_CTRL) begin
            run_q <= hwdata[CTRL_RUN];
         end
         if (busAddr_q == A_REGSEL) begin
            regSel_q <= hwdata[SELW-1:0];
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

endmodule // mca_datapath

// ===== mca_pkg.sv
package mca_pkg;
   localparam int W    = 16;
   localparam int SELW = 5;
   localparam int NREG = 32;

   // Opcodes, word bits 0-3
   localparam logic [3:0] OP_AND  = 4'h1;
   localparam logic [3:0] OP_OR   = 4'h2;
   localparam logic [3:0] OP_XOR  = 4'h3;
   localparam logic [3:0] OP_ADD  = 4'h4;
   localparam logic [3:0] OP_DIV  = 4'h6;
   localparam logic [3:0] OP_AND_IMMEDIATE = 4'h9;
   localparam logic [3:0] OP_ORI  = 4'hA;
   localparam logic [3:0] OP_XOR_IMMEDIATE = 4'hB;
   localparam logic [3:0] OP_ADD_IMMEDIATE = 4'hC;
   localparam logic [3:0] OP_LOAD = 4'hF;

   // Field positions, bit 0 is the most significant bit
   localparam int BSEL_POS [SELW] = '{4, 8, 9, 10, 11};
   localparam int DSEL_POS [SELW] = '{5, 12, 13, 14, 15};
   localparam int ASEL_POS [SELW] = '{8, 0, 1, 2, 3};
   localparam int SHF_POS  [3]    = '{5, 6, 7};
   localparam int SO_POS   = 9;
   localparam int SI_POS   = 10;
   localparam int CI_POS   = 14;
   localparam int P1_POS   = 15;
   localparam int LINK_REG = 2;

   typedef enum logic [2:0] {
      SH_NONE, SH_R1, SH_L1, SH_SK, SH_SE, SH_R8, SH_L8, SH_EX
   } mca_shift_e;

   // Register offsets on the bus
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_REGSEL = 8'h08;
   localparam logic [7:0] A_REGDAT = 8'h0C;
   localparam int         AW       = 8;

   // Field layouts
   localparam int CTRL_RUN  = 0;
   localparam int ST_CARRY  = 0;
   localparam int ST_OVFL   = 1;
   localparam int ST_SHC    = 2;
   localparam int ST_BUSY   = 3;
   localparam logic CTRL_RUN_RST = 1'b0;
endpackage

// ===== mca_rom_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Table ROM seen by the load instruction
// ---------------------------------------------------------------
module mca_rom_model (
   // Table port
   input  wire logic [mca_pkg::W-1:0] romAddr,
   output logic      [mca_pkg::W-1:0] romData
);
   import mca_pkg::*;
   // Answers the address within the same cycle; fixed scrambled contents
   assign romData = {romAddr[7:0], romAddr[15:8]} ^ 16'h5A3C;
endmodule // mca_rom_model

// ===== mca_datapath_properties.sv
`timescale 1ns/10ps
module mca_datapath_chk (
   // Clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   // Instruction port
   input wire logic                  instrValid,
   input wire logic [mca_pkg::W-1:0] instrEven,
   input wire logic [mca_pkg::W-1:0] instrOdd,
   input wire logic                  instrReady,
   input wire logic [mca_pkg::W-1:0] romAddr,
   // Register bus
   input wire logic                  hsel,
   input wire logic [31:0]           haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   input wire logic                  hreadyout,
   input wire logic [31:0]           hrdata,
   input wire logic                  hresp
);
   import mca_pkg::*;
   // ------------------------------------------------------------
   // Decodes
   // ------------------------------------------------------------
   wire take   = hsel && htrans[1] && hready;
   wire rdTake = take && !hwrite;
   wire accept = instrValid && instrReady;
   wire isLoad = accept && instrEven[15:12] == OP_LOAD;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   ready_always_a: assert property (hreadyout)
      else $error("bus wait state inserted");
   okay_resp_a: assert property (!hresp)
      else $error("bus error response");
   reset_clear_a: assert property (disable iff (1'b0)
      !rst_n |=> romAddr == '0 && hrdata == '0 && !instrReady)
      else $error("outputs not cleared by reset");
   load_stall_a: assert property (isLoad |=> !instrReady ##1 instrReady)
      else $error("table load not two cycles");
   one_cycle_a: assert property (accept && !isLoad |=> instrReady)
      else $error("instruction took more than one cycle");
   load_addr_a: assert property (isLoad |=>
      (romAddr & $past(instrOdd)) == $past(instrOdd))
      else $error("table address lacks index field");
   unmapped_zero_a: assert property (rdTake && haddr[7:0] > A_REGDAT
      |=> hrdata == '0)
      else $error("unmapped read not zero");
   status_width_a: assert property (rdTake && haddr[7:0] == A_STATUS
      |=> hrdata[31:4] == '0)
      else $error("status upper bits set");
   regdata_width_a: assert property (rdTake && haddr[7:0] == A_REGDAT
      |=> hrdata[31:16] == '0)
      else $error("register view upper bits set");
   hold_data_a: assert property (!take |=> $stable(hrdata))
      else $error("read data changed without request");
   load_seen_c: cover property (isLoad);
   b2b_seen_c: cover property (accept ##1 accept);
   view_seen_c: cover property (rdTake && haddr[7:0] == A_REGDAT);
endmodule // mca_datapath_chk

bind mca_datapath mca_datapath_chk u_chk (.*);

// ===== tb.sv
`timescale 1ns/10ps
module tb;
   import mca_pkg::*;
   logic        clk_sys, rst_n, instrValid, hsel, hwrite;
   logic [15:0] instrEven, instrOdd;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [63:0] row;
   wire logic        instrReady, hreadyout, hresp;
   wire logic [15:0] romAddr, romData;
   wire logic [31:0] hrdata;
   int          errors, num_checks, i;
   // Op, shift, mods (spill entry carry plus-one), status, B, A, dest
   localparam logic [63:0] ROWS [29] = '{
      64'h1000_FF00_F0F0_F000, 64'h2000_00FF_0F0F_0FFF,
      64'h3000_FFFF_1234_EDCB, 64'h4002_7FFF_0001_8000,
      64'h4001_FFFF_0002_0001, 64'h4000_0001_0001_0002,
      64'h4003_8000_8000_0000, 64'h4020_0001_0001_0003,
      64'h4010_0001_0001_0003, 64'h2100_0000_8001_4000,
      64'h2200_0000_8001_0002, 64'h2300_0000_8003_4001,
      64'h2400_0000_34A5_FFA5, 64'h2500_0000_ABCD_00AB,
      64'h2600_0000_ABCD_CD00, 64'h2700_0000_ABCD_CDAB,
      64'h4301_FFFF_0003_8001, 64'h2301_0000_0000_8000,
      64'h6001_0005_FFFD_0002, 64'h6084_0001_FFFD_0002,
      64'h9004_F0F0_3C3C_3030, 64'hA004_F0F0_3C3C_FCFC,
      64'hB004_F0F0_3C3C_CCCC, 64'hC004_FFFF_0001_0000,
      64'h2080_0000_0001_0001, 64'h2184_0000_0001_0000,
      64'h2244_0000_0000_0001, 64'h2344_0000_0000_8000,
      64'h2144_0000_0000_8000};

   mca_datapath uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .instrValid(instrValid), .instrEven(instrEven), .instrOdd(instrOdd),
      .instrReady(instrReady), .romAddr(romAddr), .romData(romData),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   mca_rom_model rom (.romAddr(romAddr), .romData(romData));

   always #2 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] ev(logic [3:0] op, logic [4:0] b, d);
      logic [0:15] w;
      w = '0;
      w[0:3] = op;
      w[4] = b[4];
      w[5] = d[4];
      w[8:11] = b[3:0];
      w[12:15] = d[3:0];
      return w;
   endfunction
   function automatic logic [15:0] od(logic [4:0] a, logic [2:0] sh,
                                      logic [3:0] m);
      logic [0:15] w;
      w = '0;
      w[0:3] = a[3:0];
      w[8] = a[4];
      w[5:7] = sh;
      {w[9], w[10], w[14], w[15]} = m;
      return w;
   endfunction
   task check(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task await(input bit onBus);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((onBus ? hreadyout : instrReady) !== 1'b1 && n < 50);
      if ((onBus ? hreadyout : instrReady) !== 1'b1) begin
         errors++;
         finish_test();
      end
   endtask
   task ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      await(1);
      htrans <= 2'b00;
      hwdata <= wd;
      await(1);
      r = hrdata;
   endtask
   task rreg(input logic [4:0] idx, output logic [31:0] r);
      ahb(1, A_REGSEL, {27'h0, idx}, r);
      ahb(0, A_REGDAT, 0, r);
   endtask
   task issue(input logic [15:0] e, o);
      instrValid <= 1'b1;
      instrEven <= e;
      instrOdd <= o;
      await(0);
   endtask
   task done;
      instrValid <= 1'b0;
      @(posedge clk_sys);
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {clk_sys, rst_n, instrValid, hsel, hwrite} = '0;
      {htrans, haddr, hwdata, instrEven, instrOdd} = '0;
      hsize = 3'b010;
      errors = 0;
      num_checks = 0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      ahb(0, A_CTRL, 0, rd);
      check("ctrl", rd, 0);
      ahb(0, A_STATUS, 0, rd);
      check("status", rd, 0);
      instrValid <= 1'b1;
      instrEven <= ev(OP_XOR_IMMEDIATE, 0, 7);
      repeat (3) @(posedge clk_sys);
      check("ready", {31'h0, instrReady}, 0);
      instrValid <= 1'b0;
      ahb(1, A_CTRL, 1, rd);
      for (i = 0; i < 29; i++) begin
         row = ROWS[i];
         issue(ev(OP_XOR_IMMEDIATE, 0, 3), row[31:16]);
         issue(ev(OP_XOR_IMMEDIATE, 0, 4), row[47:32]);
         if (row[63])
            issue(ev(row[63:60], 4, 5), row[31:16]);
         else
            issue(ev(row[63:60], 4, 5), od(3, row[58:56], row[55:52]));
         done();
         rreg(5, rd);
         check("dest", rd, {16'h0, row[15:0]});
         ahb(0, A_STATUS, 0, rd);
         check("status", rd, {28'h0, row[51:48]});
      end
      issue(ev(OP_XOR_IMMEDIATE, 0, 2), 16'h0100);
      issue(ev(OP_XOR_IMMEDIATE, 0, 4), 16'h0F0F);
      issue(ev(OP_LOAD, 4, 6), 16'h0023);
      issue(ev(OP_XOR_IMMEDIATE, 0, 7), 16'h55AA);
      done();
      rreg(6, rd);
      check("load", rd, 32'h0000_7632);
      rreg(7, rd);
      check("next", rd, 32'h0000_55AA);
      ahb(0, 32'h0000_0040, 0, rd);
      check("unmapped", rd, 0);
      ahb(1, 32'h0000_0040, 32'hFFFF_FFFF, rd);
      ahb(0, A_CTRL, 0, rd);
      check("ctrl", rd, 1);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rreg(7, rd);
      check("cleared", rd, 0);
      ahb(0, A_CTRL, 0, rd);
      check("ctrl", rd, 0);
      finish_test();
   end
endmodule // tb
